// >>> design/mrb_pkg.sv
/*
  shared constants and types for the mode register / read burst order pair.
  assumes one 250 MHz clock for both ends and a simplified command link.
*/
package mrb_pkg;
  // mode register addresses
  localparam logic [5:0] MA_STATUS   = 6'h00;
  localparam logic [5:0] MA_CONFIG   = 6'h01;
  localparam logic [5:0] MA_SETPOINT = 6'h0D;
  // status register fields
  localparam int         ST_REFRESH_BIT = 0;
  localparam int         ST_LATENCY_BIT = 1;
  localparam int         ST_SELFTEST_LO = 3;
  localparam logic       REFRESH_MODE   = 1'b0;
  localparam logic       LATENCY_NORMAL = 1'b0;
  // self-test codes
  localparam logic [1:0] ZQ_NOT_SUPP  = 2'h0;
  localparam logic [1:0] ZQ_GND_FLOAT = 2'h1;
  localparam logic [1:0] ZQ_SHORT_VDD = 2'h2;
  localparam logic [1:0] ZQ_OK        = 2'h3;
  // config register fields
  localparam int         CF_BL_LO   = 0;
  localparam int         CF_WRPRE   = 2;
  localparam int         CF_RDPRE   = 3;
  localparam int         CF_NWR_LO  = 4;
  localparam int         CF_READ_POSTAMBLE_LEN    = 7;
  localparam logic [1:0] BL_FIX16   = 2'h0;
  localparam logic [1:0] BL_FIX32   = 2'h1;
  localparam logic [1:0] BL_OTF     = 2'h2;
  localparam logic [7:0] CFG_RESET  = 8'h04;
  localparam logic [7:0] CFG_WO_MSK = 8'h70;
  // setpoint control fields
  localparam int         SP_WR_BIT  = 6;
  localparam int         SP_OP_BIT  = 7;
  // timing
  localparam int         CLK_PERIOD_PS  = 4000;
  localparam int         CAL_LATCH_WAIT_NS = 30;
  localparam int         CAL_LATCH_CYC  =
    (CAL_LATCH_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // controller register byte offsets
  localparam logic [3:0] AV_CMD    = 4'h0;
  localparam logic [3:0] AV_ADDR   = 4'h4;
  localparam logic [3:0] AV_WDATA  = 4'h8;
  localparam logic [3:0] AV_STATUS = 4'hC;
  localparam int         AV_OTF_BIT = 8;

  typedef enum logic [2:0] {
    OP_NONE, OP_MRW, OP_MRR, OP_ZQ_START, OP_ZQ_LATCH, OP_RD, OP_WR, OP_WR_AP
  } mrb_op_t;

  function automatic logic [5:0] mrb_nwr(input logic [2:0] code);
    case (code)
      3'h0:    mrb_nwr = 6'h06;
      3'h1:    mrb_nwr = 6'h0A;
      3'h2:    mrb_nwr = 6'h10;
      3'h3:    mrb_nwr = 6'h14;
      3'h4:    mrb_nwr = 6'h18;
      3'h5:    mrb_nwr = 6'h1E;
      3'h6:    mrb_nwr = 6'h22;
      default: mrb_nwr = 6'h28;
    endcase
  endfunction
endpackage

// >>> design/mrb_link_if.sv
/*
  command link between memory controller end and dram end.
  assumes both ends on the same clock; no tristate on this abstraction.
*/
`timescale 1ns/1ns
interface mrb_link_if;
  import mrb_pkg::*;
  logic       cmd_valid;
  mrb_op_t    cmd_op;
  logic [5:0] cmd_addr;
  logic [7:0] cmd_wdata;
  logic       cmd_bl32;
  logic       busy;
  logic       rvalid;
  logic [7:0] rdata;

  modport ctrl (output cmd_valid, cmd_op, cmd_addr, cmd_wdata, cmd_bl32,
                input  busy, rvalid, rdata);
  modport dram (input  cmd_valid, cmd_op, cmd_addr, cmd_wdata, cmd_bl32,
                output busy, rvalid, rdata);
endinterface

// >>> design/mrb_dram_end.sv
/*
  dram end: status and config mode registers, setpoint copies, impedance
  self-test, write recovery count and read burst address order.
  assumes impedance pin sense inputs are asynchronous and commands arrive
  only while busy is low.
*/
// Implementation choice: the command link port (mrb_link_if.dram).
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module mrb_dram_end (
  // clock and reset
  input  wire logic       CLOCK_I,
  input  wire logic       RST_B_I,
  // command link
  mrb_link_if.dram        LINK,
  // impedance pin sense
  input  wire logic       ZQ_PIN_GND_I,
  input  wire logic       ZQ_PIN_VDD_I,
  // operating settings
  output logic            BL32_SEL_O,
  output logic            WR_PRE_2CK_O,
  output logic            RD_PRE_TOGGLE_O,
  output logic            RD_PST_LONG_O,
  output logic            FACTORY_TRIM_O,
  // read burst word order and precharge
  output logic            WORD_VALID_O,
  output logic [4:0]      WORD_ADDR_O,
  output logic            PRECHARGE_O
);
  import mrb_pkg::*;

  typedef struct packed {
    logic [1:0]      sync1;
    logic [1:0]      sync2;
    logic            setpoint_write_select;
    logic            setpoint_operate_select;
    logic [1:0][7:0] cfg;
    logic            zq_started;
    logic            lat_run;
    logic [4:0]      lat_cnt;
    logic [1:0]      selftest;
    logic            trim;
    logic            rd_run;
    logic [4:0]      k;
    logic            rd_bl32;
    logic [4:2]      col;
    logic            wr_run;
    logic [5:0]      wr_cnt;
    logic [7:0]      rdata;
    logic            rvalid;
    logic            wvalid;
    logic [4:0]      waddr;
    logic            prech;
  } mrb_dram_st_t;

  mrb_dram_st_t s_q, s_d;
  logic [7:0]   act_cfg;
  logic [7:0]   sel_cfg;
  logic         otf_bl32;

  assign act_cfg = s_q.cfg[s_q.setpoint_operate_select];
  assign sel_cfg = s_q.cfg[s_q.setpoint_write_select];

  // burst length decode, reserved code behaves as 16
  always_comb begin
    case (act_cfg[CF_BL_LO +: 2])
      BL_FIX32: otf_bl32 = 1'b1;
      BL_OTF:   otf_bl32 = LINK.cmd_bl32;
      default:  otf_bl32 = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d        = s_q;
    s_d.sync1  = {ZQ_PIN_VDD_I, ZQ_PIN_GND_I};
    s_d.sync2  = s_q.sync1;
    s_d.rvalid = 1'b0;
    s_d.prech  = 1'b0;
    s_d.wvalid = 1'b0;
    if (LINK.cmd_valid) begin
      case (LINK.cmd_op)
        OP_MRW: begin
          if (LINK.cmd_addr == MA_CONFIG) begin
            s_d.cfg[s_q.setpoint_write_select] = LINK.cmd_wdata;
          end else if (LINK.cmd_addr == MA_SETPOINT) begin
            s_d.setpoint_write_select = LINK.cmd_wdata[SP_WR_BIT];
            s_d.setpoint_operate_select = LINK.cmd_wdata[SP_OP_BIT];
          end
        end
        OP_MRR: begin
          s_d.rvalid = 1'b1;
          case (LINK.cmd_addr)
            MA_STATUS: begin
              s_d.rdata                       = 8'h00;
              s_d.rdata[ST_REFRESH_BIT]       = REFRESH_MODE;
              s_d.rdata[ST_LATENCY_BIT]       = LATENCY_NORMAL;
              s_d.rdata[ST_SELFTEST_LO +: 2]  = s_q.selftest;
            end
            MA_CONFIG:   s_d.rdata = sel_cfg & ~CFG_WO_MSK;
            MA_SETPOINT: begin
              s_d.rdata            = 8'h00;
              s_d.rdata[SP_WR_BIT] = s_q.setpoint_write_select;
              s_d.rdata[SP_OP_BIT] = s_q.setpoint_operate_select;
            end
            default:     s_d.rdata = 8'h00;
          endcase
        end
        OP_ZQ_START: begin
          if (!s_q.trim) begin
            s_d.zq_started = 1'b1;
          end
        end
        OP_ZQ_LATCH: begin
          if (!s_q.trim && s_q.zq_started) begin
            s_d.lat_run = 1'b1;
            s_d.lat_cnt = 5'(CAL_LATCH_CYC - 1);
          end
        end
        OP_RD: begin
          s_d.rd_run  = 1'b1;
          s_d.k       = 5'h00;
          s_d.rd_bl32 = otf_bl32;
          s_d.col     = LINK.cmd_addr[4:2];
        end
        OP_WR_AP: begin
          s_d.wr_run = 1'b1;
          s_d.wr_cnt = mrb_nwr(act_cfg[CF_NWR_LO +: 3]) - 6'h01;
        end
        default: ;
      endcase
    end
    if (s_q.lat_run) begin
      if (s_q.lat_cnt == 5'h00) begin
        s_d.lat_run    = 1'b0;
        s_d.zq_started = 1'b0;
        if (s_q.sync2[0]) begin
          s_d.selftest = ZQ_GND_FLOAT;
        end else if (s_q.sync2[1]) begin
          s_d.selftest = ZQ_SHORT_VDD;
        end else begin
          s_d.selftest = ZQ_OK;
        end
        s_d.trim = s_q.sync2[0] | s_q.sync2[1];
      end else begin
        s_d.lat_cnt = s_q.lat_cnt - 5'h01;
      end
    end
    if (s_q.rd_run) begin
      s_d.wvalid = 1'b1;
      s_d.waddr[3:0] = {s_q.col[3:2], 2'b00} + s_q.k[3:0];
      s_d.waddr[4]   = s_q.rd_bl32 & (s_q.col[4] ^ s_q.k[4]);
      s_d.k          = s_q.k + 5'h01;
      if (s_q.k == {s_q.rd_bl32, 4'hF}) begin
        s_d.rd_run = 1'b0;
      end
    end
    if (s_q.wr_run) begin
      if (s_q.wr_cnt == 6'h00) begin
        s_d.wr_run = 1'b0;
        s_d.prech  = 1'b1;
      end else begin
        s_d.wr_cnt = s_q.wr_cnt - 6'h01;
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s_q          <= '0;
      s_q.cfg[0]   <= CFG_RESET;
      s_q.cfg[1]   <= CFG_RESET;
      s_q.selftest <= ZQ_NOT_SUPP;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign LINK.busy       = s_q.rd_run | s_q.wr_run | s_q.lat_run;
  assign LINK.rvalid     = s_q.rvalid;
  assign LINK.rdata      = s_q.rdata;
  assign BL32_SEL_O      = act_cfg[CF_BL_LO];
  assign WR_PRE_2CK_O    = act_cfg[CF_WRPRE];
  assign RD_PRE_TOGGLE_O = act_cfg[CF_RDPRE];
  assign RD_PST_LONG_O   = act_cfg[CF_READ_POSTAMBLE_LEN];
  assign FACTORY_TRIM_O  = s_q.trim;
  assign WORD_VALID_O    = s_q.wvalid;
  assign WORD_ADDR_O     = s_q.waddr;
  assign PRECHARGE_O     = s_q.prech;
endmodule

// >>> design/mrb_ctrl_end.sv
/*
  controller end: avalon-mm slave with waitrequest, issues link commands.
  assumes software writes ADDR/WDATA before CMD, same clock as dram end.
*/
`timescale 1ns/1ns
module mrb_ctrl_end (
  // clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        RST_B_I,
  // avalon-mm slave
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // command link
  mrb_link_if.ctrl         LINK
);
  import mrb_pkg::*;

  typedef struct packed {
    logic       pend;
    logic       cvalid;
    mrb_op_t    op;
    logic       bl32;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       rd_ack;
    logic [31:0] rdd;
  } mrb_ctrl_st_t;

  mrb_ctrl_st_t s_q, s_d;
  logic         cmd_hit;
  logic         link_busy;

  assign link_busy = s_q.pend | s_q.cvalid | LINK.busy;
  assign cmd_hit   = AVS_WRITE_I && AVS_ADDRESS_I == AV_CMD;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d        = s_q;
    s_d.cvalid = 1'b0;
    s_d.rd_ack = 1'b0;
    if (AVS_WRITE_I) begin
      case (AVS_ADDRESS_I)
        AV_ADDR:  s_d.addr  = AVS_WRITEDATA_I[5:0];
        AV_WDATA: s_d.wdata = AVS_WRITEDATA_I[7:0];
        AV_CMD: begin
          if (!link_busy) begin
            s_d.op     = mrb_op_t'(AVS_WRITEDATA_I[2:0]);
            s_d.bl32   = AVS_WRITEDATA_I[AV_OTF_BIT];
            s_d.cvalid = 1'b1;
            s_d.pend   = mrb_op_t'(AVS_WRITEDATA_I[2:0]) == OP_MRR;
          end
        end
        default: ;
      endcase
    end
    if (LINK.rvalid) begin
      s_d.pend  = 1'b0;
      s_d.rdata = LINK.rdata;
    end
    if (AVS_READ_I && !s_q.rd_ack) begin
      s_d.rd_ack = 1'b1;
      case (AVS_ADDRESS_I)
        AV_ADDR:   s_d.rdd = {26'h0, s_q.addr};
        AV_WDATA:  s_d.rdd = {24'h0, s_q.wdata};
        AV_STATUS: s_d.rdd = {16'h0, s_q.rdata, 7'h00, link_busy};
        default:   s_d.rdd = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign AVS_WAITREQUEST_O = (AVS_READ_I && !s_q.rd_ack) || (cmd_hit && link_busy);
  assign AVS_READDATA_O    = s_q.rdd;
  assign LINK.cmd_valid    = s_q.cvalid;
  assign LINK.cmd_op       = s_q.op;
  assign LINK.cmd_addr     = s_q.addr;
  assign LINK.cmd_wdata    = s_q.wdata;
  assign LINK.cmd_bl32     = s_q.bl32;
endmodule

// >>> tb/mrb_link_checker.sv
/*
  checker on the command link between the two ends.
  assumes one clock and active-low async reset.
*/
`timescale 1ns/1ns
////////////////////////////////////////
module mrb_link_checker
  import mrb_pkg::*;
(
  input wire logic       CLOCK_I,
  input wire logic       RST_B_I,
  input wire logic       cmd_valid,
  input wire mrb_op_t    cmd_op,
  input wire logic [5:0] cmd_addr,
  input wire logic       busy,
  input wire logic       rvalid,
  input wire logic [7:0] rdata
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);
  wire mode_reg_read_cmd = cmd_valid && cmd_op == OP_MRR;
  property p_mrr_ans; mode_reg_read_cmd |=> rvalid; endproperty
  a_mrr_ans:
    assert property (p_mrr_ans) else $error("read without answer");
  property p_rv_src; rvalid |-> $past(cmd_valid) && $past(cmd_op) == OP_MRR; endproperty
  a_rv_src:
    assert property (p_rv_src) else $error("answer without read");
  property p_refr; mode_reg_read_cmd && cmd_addr == MA_STATUS |=> rdata[0] == REFRESH_MODE; endproperty
  a_refr:
    assert property (p_refr) else $error("refresh bit wrong");
  property p_lat; mode_reg_read_cmd && cmd_addr == MA_STATUS |=> rdata[1] == LATENCY_NORMAL; endproperty
  a_lat:
    assert property (p_lat) else $error("latency bit wrong");
  property p_wo; mode_reg_read_cmd && cmd_addr == MA_CONFIG |=> rdata[6:4] == 3'h0; endproperty
  a_wo:
    assert property (p_wo) else $error("recovery field readable");
  property p_pre; mode_reg_read_cmd && cmd_addr == MA_CONFIG |=> rdata[CF_WRPRE]; endproperty
  a_pre:
    assert property (p_pre) else $error("preamble bit lost");
  property p_rd; cmd_valid && cmd_op == OP_RD |=> busy [*8]; endproperty
  a_rd:
    assert property (p_rd) else $error("burst too short");
  property p_wrap; cmd_valid && cmd_op == OP_WR_AP |=> busy [*6]; endproperty
  a_wrap:
    assert property (p_wrap) else $error("recovery too short");
endmodule

// >>> tb/dram_mode_regs_burst_order_tb.sv
/*
  bench joining controller end and dram end; avalon master and model.
  assumes the design package and link interface are compiled first.
*/
`timescale 1ns/1ns
////////////////////////////////////////
module dram_mode_regs_burst_order_tb;
  import mrb_pkg::*;
  logic        clk = 0, rst_b = 0, gnd = 0, vdd = 0, rd = 0, wr = 0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0, rdq, q;
  logic        wq, wv, pre, trim, bl32o, wpre, rpre, read_postamble_len;
  logic [4:0]  wa;
  logic [4:0]  got[$];
  int          mismatches = 0, check_count = 0, cyc = 0, tcmd, dt, e;
  int          cp[2], ws, os;
  int          write_recovery_cycles[8] = '{6, 10, 16, 20, 24, 30, 34, 40};
  mrb_link_if link();
  always #2 clk = ~clk;
  mrb_ctrl_end i_mrb_ctrl_end (.CLOCK_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdq),
    .AVS_WAITREQUEST_O(wq), .LINK(link.ctrl));
  mrb_dram_end i_mrb_dram_end (.CLOCK_I(clk), .RST_B_I(rst_b), .LINK(link.dram),
    .ZQ_PIN_GND_I(gnd), .ZQ_PIN_VDD_I(vdd), .BL32_SEL_O(bl32o), .WR_PRE_2CK_O(wpre),
    .RD_PRE_TOGGLE_O(rpre), .RD_PST_LONG_O(read_postamble_len), .FACTORY_TRIM_O(trim),
    .WORD_VALID_O(wv), .WORD_ADDR_O(wa), .PRECHARGE_O(pre));
  mrb_link_checker i_chk (.CLOCK_I(clk), .RST_B_I(rst_b), .cmd_valid(link.cmd_valid),
    .cmd_op(link.cmd_op), .cmd_addr(link.cmd_addr), .busy(link.busy),
    .rvalid(link.rvalid), .rdata(link.rdata));
  // word monitor, recovery timer, timeout well above expected run
  always @(posedge clk) begin
    cyc++;
    if (wv === 1'b1) got.push_back(wa);
    if (link.cmd_valid === 1'b1) tcmd = cyc;
    if (pre === 1'b1) dt = cyc - tcmd;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, y);
    check_count++;
    if (x !== y) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", n, x, y);
    end
  endtask
  task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    // waitrequest and read data sampled at the same rising edge
    do @(posedge clk); while (wq !== 1'b0);
    q = rdq;
    wr <= 0;
    rd <= 0;
  endtask
  task automatic cmd(input mrb_op_t o, input int a, d, b);
    av(AV_ADDR, 1, a);
    av(AV_WDATA, 1, d);
    av(AV_CMD, 1, 32'({b[0], 5'h0, o}));
    do av(AV_STATUS, 0, 0); while (q[0] !== 1'b0);
    repeat (3) @(posedge clk);
    if (o == OP_MRW && a == MA_SETPOINT) begin
      ws = d[6];
      os = d[7];
    end
    if (o == OP_MRW && a == MA_CONFIG) cp[ws] = d;
  endtask
  task automatic rst();
    rst_b <= 0;
    repeat (12) @(posedge clk);
    rst_b <= 1;
    cp = '{4, 4};
    ws = 0;
    os = 0;
  endtask
  task automatic outs();
    chk("bl32", cp[os][0], bl32o);
    chk("wpre", cp[os][2], wpre);
    chk("rpre", cp[os][3], rpre);
    chk("read_postamble_len", cp[os][7], read_postamble_len);
  endtask
  task automatic burst(input int col, b);
    int n;
    n = (cp[os][1:0] == 1 || (cp[os][1:0] == 2 && b)) ? 32 : 16;
    got.delete();
    cmd(OP_RD, col, 0, b);
    chk("words", n, got.size());
    foreach (got[k]) chk("word", (4 * col[3:2] + k) % 16 + ((n == 32) ? 16 * (col[4] ^ (k / 16)) : 0), got[k]);
  endtask
  task automatic zq_seq(input logic g, v, input int x);
    gnd <= g;
    vdd <= v;
    cmd(OP_ZQ_START, 0, 0, 0);
    cmd(OP_ZQ_LATCH, 0, 0, 0);
    repeat (CAL_LATCH_CYC) @(posedge clk);
    cmd(OP_MRR, MA_STATUS, 0, 0);
    chk("selftest", x, q[12:11]);
    chk("trim", x inside {1, 2}, trim);
  endtask
  initial begin
    void'($urandom(32'h4a031770));
    rst();
    cmd(OP_MRR, MA_CONFIG, 0, 0);
    chk("cfg", CFG_RESET, q[15:8]);
    outs();
    av(4'h2, 1, 32'hFF);
    av(4'h2, 0, 0);
    chk("unmapped", 0, q);
    // write one copy while operating from the other
    for (int s = 0; s < 5; s++) begin
      cmd(OP_MRW, MA_SETPOINT, {!s[0], s[0], 6'h0}, 0);
      cmd(OP_MRR, MA_SETPOINT, 0, 0);
      chk("setpoint", {os[0], ws[0], 6'h0}, q[15:8]);
      cmd(OP_MRW, MA_CONFIG, ($urandom & 8'hF8) | 4 | (s % 4), 0);
      cmd(OP_MRR, MA_CONFIG, 0, 0);
      chk("cfg", cp[ws] & 8'h8F, q[15:8]);
      outs();
      burst($urandom & 63, 0);
      burst($urandom & 63, 1);
    end
    cmd(OP_MRW, MA_SETPOINT, 0, 0);
    for (int n = 0; n < 8; n++) begin
      cmd(OP_MRW, MA_CONFIG, n * 16 + 4, 0);
      dt = -1;
      cmd(OP_WR_AP, 0, 0, 0);
      chk("recovery", write_recovery_cycles[n] + 1, dt);
    end
    // plain write must not start a precharge count
    dt = -1;
    cmd(OP_WR, 0, 0, 0);
    chk("plain write", -1, dt);
    for (int p = 0; p < 3; p++) begin
      rst();
      cmd(OP_MRR, MA_STATUS, 0, 0);
      chk("status", 0, q[15:8]);
      // latch without a prior start leaves the result unset
      cmd(OP_ZQ_LATCH, 0, 0, 0);
      cmd(OP_MRR, MA_STATUS, 0, 0);
      chk("latch only", ZQ_NOT_SUPP, q[12:11]);
      zq_seq(p == 1, p == 2, (p == 0) ? 3 : p);
    end
    zq_seq(0, 0, 2);
    report_and_stop();
  end
endmodule
